// [logic/rrs_pkg.sv]
// Constants, enumerations and carriers of the receiver switch control block
package rrs_pkg;
   // ********************************************************************
   // Register byte addresses and field positions
   // ********************************************************************
   localparam logic [7:0] ADDR_CONFIG   = 8'h00;
   localparam logic [7:0] ADDR_MUTE     = 8'h04;
   localparam logic [7:0] ADDR_ATT_HOST = 8'h10;
   localparam logic [7:0] ADDR_ATT_MGMT = 8'h20;
   localparam logic [7:0] ADDR_RESTORE  = 8'h30;
   localparam logic [7:0] ADDR_STATUS   = 8'h40;
   localparam logic [7:0] ADDR_FER_SEC  = 8'h44;
   localparam logic [7:0] ADDR_FER_MIN  = 8'h48;
   localparam logic [7:0] ADDR_FER_HOUR = 8'h4C;
   localparam logic [7:0] ADDR_FER_DAY  = 8'h50;
   localparam logic [7:0] ADDR_FER_CLR  = 8'h54;
   localparam int CFG_BAND_LSB = 0;
   localparam int CFG_INTRED   = 2;
   localparam int CFG_EXTRED   = 3;
   localparam int CFG_SW_LSB   = 4;
   localparam int CFG_CNT_CLR  = 6;
   localparam int RESTORE_BIT  = 0;
   // ********************************************************************
   // Modes
   // ********************************************************************
   typedef enum logic [1:0] {
      BAND_5_40  = 2'h0,
      BAND_7_42  = 2'h1,
      BAND_10_45 = 2'h2
   } rrs_band_t;
   typedef enum logic [1:0] {
      SW_DEFLT1 = 2'h0,
      SW_DEFLT2 = 2'h1,
      SW_FORCE1 = 2'h2,
      SW_FORCE2 = 2'h3
   } rrs_sw_t;
   typedef enum logic [1:0] {
      OUT_AUTO = 2'h0,
      OUT_ON   = 2'h1,
      OUT_OFF  = 2'h2
   } rrs_outm_t;
   // ********************************************************************
   // Reset values, limits and timing
   // ********************************************************************
   localparam rrs_band_t BAND_RST    = BAND_7_42;
   localparam logic      INTRED_RST  = 1'b1;
   localparam logic      EXTRED_RST  = 1'b0;
   localparam rrs_sw_t   SW_RST      = SW_DEFLT1;
   localparam logic      CNT_CLR_RST = 1'b0;
   localparam rrs_outm_t OUTM_RST    = OUT_AUTO;
   localparam logic [7:0] ATT_RST    = 8'h00;
   localparam int ATT_MAX_TENTHS = 60;
   localparam int ATT_MAX_HALF   = 12;
   localparam int HALF_TO_TENTHS = 5;
   localparam int CLK_KHZ        = 200000;
   localparam int SECOND_MS      = 1000;
   localparam int BLINK_MS       = 250;
   localparam int SEC_CYCLES     = SECOND_MS * CLK_KHZ;
   localparam int BLINK_CYCLES   = BLINK_MS * CLK_KHZ;
   localparam logic [5:0] SEC_PER_MIN  = 6'h3C;
   localparam logic [5:0] MIN_PER_HOUR = 6'h3C;
   localparam logic [4:0] HOUR_PER_DAY = 5'h18;
   localparam logic [31:0] DIV_MIN  = 32'h0000003C;
   localparam logic [31:0] DIV_HOUR = 32'h00000E10;
   localparam logic [31:0] DIV_DAY  = 32'h00015180;
   // ********************************************************************
   // Carriers
   // ********************************************************************
   typedef struct packed {
      logic [1:0] present;
      logic [1:0] los;
      logic       ext_fail;
   } rrs_pins_t;
   typedef struct packed {
      rrs_band_t            band;
      logic                 int_red;
      logic                 ext_red;
      rrs_sw_t              sw;
      logic                 cnt_clr;
      rrs_outm_t [3:0]      outm;
      logic [3:0][7:0]      att;
   } rrs_cfg_t;
   typedef struct packed {
      rrs_cfg_t    cfg;
      rrs_pins_t   s1;
      rrs_pins_t   s2;
      rrs_pins_t   s3;
      rrs_pins_t   filt;
      logic [31:0] prdata;
      logic        sel;
      logic [3:0]  mute;
      logic [1:0]  rx_red;
      logic [1:0]  rx_green;
      logic        alarm_led;
      logic        major;
      logic        minor;
      logic        blink;
      logic [31:0] blink_cnt;
      logic [31:0] sec_cnt;
      logic [5:0]  sec_idx;
      logic [5:0]  min_idx;
      logic [4:0]  hour_idx;
      logic [31:0] sec_acc;
      logic [31:0] min_acc;
      logic [31:0] hour_acc;
      logic [31:0] day_acc;
      logic [31:0] fer_sec;
      logic [31:0] fer_min;
      logic [31:0] fer_hour;
      logic [31:0] fer_day;
      logic [31:0] fer_clr;
   } rrs_state_t;
endpackage : rrs_pkg

// [logic/rrs_ctrl.sv]
// Receiver selection, muting, attenuation, error rate and alarm control
`timescale 1ns/1ps
// Notes on behaviour
// - Each receiver indicator red while alarmed, green while healthy.
// - Three selectable bands; middle band after reset and restore.
// - Internal redundancy: standby receiver used only when primary failed.
// - No redundancy: primary alone, no alarm while installed and working.
// - External redundancy: act as standby until external failure signal.
// - Default selection prefers receiver one or two; one at reset.
// - Forced settings lock onto receiver one or two regardless of errors.
// - Automatic output mutes on receiver alarms in redundant mode.
// - Per channel manual on unmutes and off mutes.
// - Per channel attenuation -6..+6 dB, half dB steps, zero default.
// - Host path sets same span in tenth dB steps.
// - Error rate for last second, averages over minute, hour, day.
// - Count mode accumulates every frame error since last clear.
// - Reset mode clears accumulated error count to zero.
// - Clear leaves second, minute, hour and day counters alone.
// - Held in reset mode the count stays zero; software returns it.
// - Alarm when all outputs muted or a receiver removed in internal redundancy.
// - Alarm when a receiver loses its optical input in internal redundancy, else only when the preferred receiver does.
// - Alarms graded major, minor or fault; major/minor high or low.
// - Major alarm lights red steadily; minor alone makes it blink.
// - Restore defaults only from management module, any time.
// - Green power indicator lit whenever powered.
module rrs_ctrl #(
   parameter int unsigned SEC_CYCLES   = rrs_pkg::SEC_CYCLES,
   parameter int unsigned BLINK_CYCLES = rrs_pkg::BLINK_CYCLES
) (
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        mgmt_access,
   input  wire logic [1:0]  rx_present,
   input  wire logic [1:0]  rx_los,
   input  wire logic        ext_fail,
   input  wire logic        frame_error,
   input  wire logic        major_high_alarm,
   input  wire logic        major_low_alarm,
   input  wire logic        minor_high_alarm,
   input  wire logic        minor_low_alarm,
   input  wire logic        fault_alarm,
   output logic             rx_select,
   output logic      [3:0]  rf_mute,
   output logic      [3:0][7:0] rf_atten,
   output logic      [1:0]  band_sel,
   output logic      [1:0]  rx_led_red,
   output logic      [1:0]  rx_led_green,
   output logic             alarm_led,
   output logic             power_led
);
   // ********************************************************************
   // Helpers
   // ********************************************************************
   function automatic logic [7:0] clamp(input logic [31:0] v,
                                        input int lim);
      logic signed [31:0] sv;
      sv = $signed(v);
      if (sv > lim) begin
         clamp = 8'(lim);
      end else if (sv < -lim) begin
         clamp = 8'(-lim);
      end else begin
         clamp = sv[7:0];
      end
   endfunction : clamp

   function automatic rrs_pkg::rrs_cfg_t cfg_default();
      rrs_pkg::rrs_cfg_t c;
      c.band    = rrs_pkg::BAND_RST;
      c.int_red = rrs_pkg::INTRED_RST;
      c.ext_red = rrs_pkg::EXTRED_RST;
      c.sw      = rrs_pkg::SW_RST;
      c.cnt_clr = rrs_pkg::CNT_CLR_RST;
      for (int i = 0; i < 4; i++) begin
         c.outm[i] = rrs_pkg::OUTM_RST;
         c.att[i]  = rrs_pkg::ATT_RST;
      end
      cfg_default = c;
   endfunction : cfg_default

   rrs_pkg::rrs_state_t st_r;
   rrs_pkg::rrs_state_t st_nxt;
   rrs_pkg::rrs_pins_t  pins_in;

   logic [1:0]  fail;
   logic        pref;
   logic        standby;
   logic        auto_mute;
   logic        setup;
   logic        access;
   logic        addr_ok;
   logic        err_bump;
   logic [31:0] sec_total;
   logic [31:0] min_total;
   logic [31:0] hour_total;
   logic [31:0] rd;
   logic [1:0]  ch;

   assign pins_in.present  = rx_present;
   assign pins_in.los      = rx_los;
   assign pins_in.ext_fail = ext_fail;
   assign setup  = psel & ~penable;
   assign access = psel & penable;
   assign ch     = paddr[3:2];

   // ********************************************************************
   // Address map check
   // ********************************************************************
   always_comb begin
      if (paddr[1:0] != 2'h0) begin
         addr_ok = 1'b0;
      end else if (paddr == rrs_pkg::ADDR_CONFIG ||
                   paddr == rrs_pkg::ADDR_MUTE) begin
         addr_ok = 1'b1;
      end else if (paddr[7:4] == rrs_pkg::ADDR_ATT_HOST[7:4] ||
                   paddr[7:4] == rrs_pkg::ADDR_ATT_MGMT[7:4]) begin
         addr_ok = 1'b1;
      end else if (paddr == rrs_pkg::ADDR_RESTORE) begin
         addr_ok = 1'b1;
      end else if (paddr >= rrs_pkg::ADDR_STATUS &&
                   paddr <= rrs_pkg::ADDR_FER_CLR) begin
         addr_ok = 1'b1;
      end else begin
         addr_ok = 1'b0;
      end
   end

   // Zero wait states; read data was captured in the setup cycle
   assign pready  = 1'b1;
   assign pslverr = access & ~addr_ok;

   // ********************************************************************
   // Next state
   // ********************************************************************
   always_comb begin
      st_nxt = st_r;
      rd     = 32'h00000000;
      // Three-stage pin synchroniser, value taken once stages 2 and 3 agree
      st_nxt.s1 = pins_in;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      if (st_r.s2 == st_r.s3) begin
         st_nxt.filt = st_r.s3;
      end

      // Receiver health and selection
      fail = ~st_r.filt.present | st_r.filt.los;
      pref = (st_r.cfg.sw == rrs_pkg::SW_DEFLT2);
      case (st_r.cfg.sw)
         rrs_pkg::SW_FORCE1: st_nxt.sel = 1'b0;
         rrs_pkg::SW_FORCE2: st_nxt.sel = 1'b1;
         default: begin
            if (st_r.cfg.int_red && fail[pref] && !fail[~pref]) begin
               st_nxt.sel = ~pref;
            end else begin
               st_nxt.sel = pref;
            end
         end
      endcase
      st_nxt.rx_red   = fail;
      st_nxt.rx_green = ~fail;

      // External standby holds outputs until the primary signals failure
      standby   = st_r.cfg.ext_red & ~st_r.filt.ext_fail;
      auto_mute = (st_r.cfg.int_red | st_r.cfg.ext_red) &
                  (fail[st_r.sel] | standby);
      for (int i = 0; i < 4; i++) begin
         case (st_r.cfg.outm[i])
            rrs_pkg::OUT_AUTO: st_nxt.mute[i] = auto_mute;
            rrs_pkg::OUT_ON:   st_nxt.mute[i] = 1'b0;
            rrs_pkg::OUT_OFF:  st_nxt.mute[i] = 1'b1;
            default:           st_nxt.mute[i] = 1'b0;
         endcase
      end

      // Alarm grading; fault is shown like a major alarm
      st_nxt.major = (&st_r.mute) |
                     (st_r.cfg.int_red & ~(&st_r.filt.present)) |
                     (st_r.cfg.int_red ?
                        |(st_r.filt.present & st_r.filt.los) :
                        fail[pref]) |
                     major_high_alarm | major_low_alarm |
                     fault_alarm;
      st_nxt.minor = minor_high_alarm | minor_low_alarm;
      if (st_r.blink_cnt >= BLINK_CYCLES - 1) begin
         st_nxt.blink_cnt = 32'h00000000;
         st_nxt.blink     = ~st_r.blink;
      end else begin
         st_nxt.blink_cnt = st_r.blink_cnt + 32'h00000001;
      end
      if (st_r.major) begin
         st_nxt.alarm_led = 1'b1;
      end else if (st_r.minor) begin
         st_nxt.alarm_led = st_r.blink;
      end else begin
         st_nxt.alarm_led = 1'b0;
      end

      // Frame error windows
      err_bump   = frame_error;
      sec_total  = st_r.sec_acc + {31'h00000000, err_bump};
      min_total  = st_r.min_acc + sec_total;
      hour_total = st_r.hour_acc + min_total;
      st_nxt.sec_acc = sec_total;
      if (st_r.cfg.cnt_clr) begin
         st_nxt.fer_clr = 32'h00000000;
      end else begin
         st_nxt.fer_clr = st_r.fer_clr + {31'h00000000, err_bump};
      end
      if (st_r.sec_cnt >= SEC_CYCLES - 1) begin
         st_nxt.sec_cnt = 32'h00000000;
         st_nxt.fer_sec = sec_total;
         st_nxt.sec_acc = 32'h00000000;
         st_nxt.min_acc = min_total;
         if (st_r.sec_idx == rrs_pkg::SEC_PER_MIN - 6'h01) begin
            st_nxt.sec_idx  = 6'h00;
            st_nxt.fer_min  = min_total / rrs_pkg::DIV_MIN;
            st_nxt.min_acc  = 32'h00000000;
            st_nxt.hour_acc = hour_total;
            if (st_r.min_idx == rrs_pkg::MIN_PER_HOUR - 6'h01) begin
               st_nxt.min_idx  = 6'h00;
               st_nxt.fer_hour = hour_total / rrs_pkg::DIV_HOUR;
               st_nxt.hour_acc = 32'h00000000;
               st_nxt.day_acc  = st_r.day_acc + hour_total;
               if (st_r.hour_idx == rrs_pkg::HOUR_PER_DAY - 5'h01) begin
                  st_nxt.hour_idx = 5'h00;
                  st_nxt.fer_day  = (st_r.day_acc + hour_total) /
                                    rrs_pkg::DIV_DAY;
                  st_nxt.day_acc  = 32'h00000000;
               end else begin
                  st_nxt.hour_idx = st_r.hour_idx + 5'h01;
               end
            end else begin
               st_nxt.min_idx = st_r.min_idx + 6'h01;
            end
         end else begin
            st_nxt.sec_idx = st_r.sec_idx + 6'h01;
         end
      end else begin
         st_nxt.sec_cnt = st_r.sec_cnt + 32'h00000001;
      end

      // Register reads, captured in setup so prdata comes from a flop
      if (paddr == rrs_pkg::ADDR_CONFIG) begin
         rd[rrs_pkg::CFG_BAND_LSB +: 2] = st_r.cfg.band;
         rd[rrs_pkg::CFG_INTRED]        = st_r.cfg.int_red;
         rd[rrs_pkg::CFG_EXTRED]        = st_r.cfg.ext_red;
         rd[rrs_pkg::CFG_SW_LSB +: 2]   = st_r.cfg.sw;
         rd[rrs_pkg::CFG_CNT_CLR]       = st_r.cfg.cnt_clr;
      end else if (paddr == rrs_pkg::ADDR_MUTE) begin
         rd[7:0] = st_r.cfg.outm;
      end else if (paddr[7:4] == rrs_pkg::ADDR_ATT_HOST[7:4] ||
                   paddr[7:4] == rrs_pkg::ADDR_ATT_MGMT[7:4]) begin
         rd = 32'($signed(st_r.cfg.att[ch]));
      end else if (paddr == rrs_pkg::ADDR_STATUS) begin
         rd[0]     = st_r.sel;
         rd[2:1]   = fail;
         rd[7:4]   = st_r.mute;
         rd[8]     = st_r.major;
         rd[9]     = st_r.minor;
         rd[10]    = st_r.alarm_led;
         rd[11]    = standby;
         rd[16:12] = {fault_alarm, minor_low_alarm, minor_high_alarm,
                      major_low_alarm, major_high_alarm};
      end else if (paddr == rrs_pkg::ADDR_FER_SEC) begin
         rd = st_r.fer_sec;
      end else if (paddr == rrs_pkg::ADDR_FER_MIN) begin
         rd = st_r.fer_min;
      end else if (paddr == rrs_pkg::ADDR_FER_HOUR) begin
         rd = st_r.fer_hour;
      end else if (paddr == rrs_pkg::ADDR_FER_DAY) begin
         rd = st_r.fer_day;
      end else if (paddr == rrs_pkg::ADDR_FER_CLR) begin
         rd = st_r.fer_clr;
      end
      if (setup && !pwrite) begin
         st_nxt.prdata = rd;
      end

      // Register writes at the access edge
      if (access && pwrite && addr_ok) begin
         if (paddr == rrs_pkg::ADDR_CONFIG) begin
            // Unused band code is refused, band stays as it was
            if (pwdata[rrs_pkg::CFG_BAND_LSB +: 2] != 2'h3) begin
               st_nxt.cfg.band = rrs_pkg::rrs_band_t'(
                  pwdata[rrs_pkg::CFG_BAND_LSB +: 2]);
            end
            st_nxt.cfg.int_red = pwdata[rrs_pkg::CFG_INTRED];
            st_nxt.cfg.ext_red = pwdata[rrs_pkg::CFG_EXTRED];
            st_nxt.cfg.sw = rrs_pkg::rrs_sw_t'(
               pwdata[rrs_pkg::CFG_SW_LSB +: 2]);
            st_nxt.cfg.cnt_clr = pwdata[rrs_pkg::CFG_CNT_CLR];
         end else if (paddr == rrs_pkg::ADDR_MUTE) begin
            for (int i = 0; i < 4; i++) begin
               if (pwdata[2*i +: 2] != 2'h3) begin
                  st_nxt.cfg.outm[i] =
                     rrs_pkg::rrs_outm_t'(pwdata[2*i +: 2]);
               end
            end
         end else if (paddr[7:4] == rrs_pkg::ADDR_ATT_HOST[7:4]) begin
            st_nxt.cfg.att[ch] =
               clamp(pwdata, rrs_pkg::ATT_MAX_TENTHS);
         end else if (paddr[7:4] == rrs_pkg::ADDR_ATT_MGMT[7:4]) begin
            // Half dB units scaled to the stored tenth dB value
            st_nxt.cfg.att[ch] = 8'($signed(clamp(pwdata,
               rrs_pkg::ATT_MAX_HALF)) * rrs_pkg::HALF_TO_TENTHS);
         end else if (paddr == rrs_pkg::ADDR_RESTORE) begin
            if (mgmt_access && pwdata[rrs_pkg::RESTORE_BIT]) begin
               st_nxt.cfg = cfg_default();
            end
         end
      end
   end

   // ********************************************************************
   // State register
   // ********************************************************************
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r     <= '0;
         st_r.cfg <= cfg_default();
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata       = st_r.prdata;
   assign rx_select    = st_r.sel;
   assign rf_mute      = st_r.mute;
   assign rf_atten     = st_r.cfg.att;
   assign band_sel     = st_r.cfg.band;
   assign rx_led_red   = st_r.rx_red;
   assign rx_led_green = st_r.rx_green;
   assign alarm_led    = st_r.alarm_led;
   // Lit by the supply itself; no logic can switch it off
   assign power_led    = 1'b1;
endmodule : rrs_ctrl

// [verif/rrs_ctrl_monitor.sv]
// Port checker of the receiver switch control block
`timescale 1ns/1ps
module rrs_ctrl_monitor (
   input wire logic            ref_clk,
   input wire logic            rst_b,
   input wire logic [1:0]      rx_present,
   input wire logic [1:0]      rx_los,
   input wire logic            major_high_alarm,
   input wire logic            fault_alarm,
   input wire logic [3:0]      rf_mute,
   input wire logic [3:0][7:0] rf_atten,
   input wire logic [1:0]      band_sel,
   input wire logic [1:0]      rx_led_red,
   input wire logic [1:0]      rx_led_green,
   input wire logic            alarm_led,
   input wire logic            power_led
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   power_lamp_a: assert property (power_led)
      else $error("power lamp dark");
   band_code_a: assert property (band_sel != 2'h3)
      else $error("band code out of range");
   // Inputs must stay put past the synchroniser before lamps follow
   for (genvar i = 0; i < 2; i++) begin : g_rx
      lost_red_a: assert property (rx_los[i] [*8] |-> rx_led_red[i])
         else $error("receiver lamp not red on lost light");
      healthy_green_a: assert property (
         (rx_present[i] && !rx_los[i]) [*8] |->
         rx_led_green[i] && !rx_led_red[i])
         else $error("healthy receiver lamp not green");
   end
   for (genvar c = 0; c < 4; c++) begin : g_ch
      atten_span_a: assert property (
         $signed(rf_atten[c]) >= -60 && $signed(rf_atten[c]) <= 60)
         else $error("attenuation outside span");
   end
   major_steady_a: assert property (
      major_high_alarm [*5] |-> alarm_led [*3])
      else $error("major alarm lamp not steady");
   fault_lit_a: assert property (fault_alarm [*5] |-> alarm_led)
      else $error("fault alarm lamp dark");
   all_muted_a: assert property ((rf_mute == 4'hF) [*5] |-> alarm_led)
      else $error("all outputs muted without alarm");
endmodule : rrs_ctrl_monitor

bind rrs_ctrl rrs_ctrl_monitor u_mon (
   .ref_clk(ref_clk), .rst_b(rst_b), .rx_present(rx_present),
   .rx_los(rx_los), .major_high_alarm(major_high_alarm),
   .fault_alarm(fault_alarm), .rf_mute(rf_mute), .rf_atten(rf_atten),
   .band_sel(band_sel), .rx_led_red(rx_led_red),
   .rx_led_green(rx_led_green), .alarm_led(alarm_led),
   .power_led(power_led));

// [verif/rrs_rx_model.sv]
// Optical receiver pair and external primary as seen by the block
`timescale 1ns/1ps
module rrs_rx_model (
   input  wire logic  ref_clk,
   output logic [1:0] rx_present,
   output logic [1:0] rx_los,
   output logic       ext_fail
);
   initial {rx_present, rx_los, ext_fail} = 5'h18;
   // Levels move just after an edge and hold until told otherwise
   task automatic set_rx(input logic [1:0] p, input logic [1:0] l,
                         input logic e);
      @(posedge ref_clk);
      rx_present <= p;
      rx_los     <= l & p;
      ext_fail   <= e;
   endtask : set_rx
endmodule : rrs_rx_model

// [verif/rrs_ctrl_tb.sv]
// Self-checking bench of the receiver switch control block
`timescale 1ns/1ps
module rrs_ctrl_tb;
   logic            ref_clk = 1'b0;
   logic            rst_b = 1'b0;
   logic            psel = 1'b0;
   logic            penable = 1'b0;
   logic            pwrite = 1'b0;
   logic [7:0]      paddr = 8'h00;
   logic [31:0]     pwdata = 32'h0;
   logic [31:0]     prdata;
   logic            pready;
   logic            pslverr;
   logic            mgmt_access = 1'b0;
   logic            frame_error = 1'b0;
   logic [4:0]      alm = 5'h00;
   logic [1:0]      rx_present;
   logic [1:0]      rx_los;
   logic            ext_fail;
   logic            rx_select;
   logic [3:0]      rf_mute;
   logic [3:0][7:0] rf_atten;
   logic [1:0]      band_sel;
   logic            alarm_led;
   logic            perr;
   logic [31:0]     q;
   int              mismatches = 0;
   int              n_checks = 0;
   // ****************************************************************
   // Instances
   // ****************************************************************
   rrs_ctrl #(.SEC_CYCLES(20), .BLINK_CYCLES(4)) dut (
      .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .mgmt_access(mgmt_access),
      .rx_present(rx_present), .rx_los(rx_los), .ext_fail(ext_fail),
      .frame_error(frame_error), .major_high_alarm(alm[4]),
      .major_low_alarm(alm[3]), .minor_high_alarm(alm[2]),
      .minor_low_alarm(alm[1]), .fault_alarm(alm[0]),
      .rx_select(rx_select), .rf_mute(rf_mute), .rf_atten(rf_atten),
      .band_sel(band_sel), .rx_led_red(), .rx_led_green(),
      .alarm_led(alarm_led), .power_led());
   rrs_rx_model m (.ref_clk(ref_clk), .rx_present(rx_present),
      .rx_los(rx_los), .ext_fail(ext_fail));
   initial forever #2.5 ref_clk = ~ref_clk;
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wt(input int c);
      repeat (c) @(posedge ref_clk);
   endtask : wt
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n = 0;
      @(posedge ref_clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q       = prdata;
      perr    = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n == 50) begin
         mismatches++;
         stop_test();
      end
   endtask : apb
   task automatic pulse(input int c);
      @(posedge ref_clk);
      frame_error <= 1'b1;
      wt(c);
      frame_error <= 1'b0;
   endtask : pulse
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_band;
      apb(1'b0, rrs_pkg::ADDR_CONFIG, 32'h0);
      chk(q, 32'h5);
      chk(rx_select, 1'b0);
      for (int b = 0; b < 4; b++) begin
         apb(1'b1, rrs_pkg::ADDR_CONFIG, 32'h4 | b);
         wt(2);
         chk(band_sel, (b == 3) ? 2 : b);
      end
      apb(1'b1, rrs_pkg::ADDR_CONFIG, 32'h5);
   endtask : t_band
   task automatic t_select;
      m.set_rx(2'h3, 2'h1, 1'b0);
      wt(12);
      chk(rx_select, 1'b1);
      chk(rf_mute, 4'h0);
      m.set_rx(2'h1, 2'h1, 1'b0);
      wt(12);
      chk(rx_select, 1'b0);
      chk(rf_mute, 4'hF);
      chk(alarm_led, 1'b1);
      m.set_rx(2'h3, 2'h0, 1'b0);
      wt(12);
      chk(rx_select, 1'b0);
      apb(1'b1, rrs_pkg::ADDR_CONFIG, 32'h15);
      wt(3);
      chk(rx_select, 1'b1);
      apb(1'b1, rrs_pkg::ADDR_CONFIG, 32'h25);
      m.set_rx(2'h3, 2'h1, 1'b0);
      wt(12);
      chk(rx_select, 1'b0);
      apb(1'b1, rrs_pkg::ADDR_CONFIG, 32'h35);
      m.set_rx(2'h3, 2'h2, 1'b0);
      wt(12);
      chk(rx_select, 1'b1);
   endtask : t_select
   task automatic t_solo;
      apb(1'b1, rrs_pkg::ADDR_CONFIG, 32'h1);
      m.set_rx(2'h1, 2'h0, 1'b0);
      wt(12);
      chk(alarm_led, 1'b0);
      chk(rf_mute, 4'h0);
      apb(1'b1, rrs_pkg::ADDR_CONFIG, 32'h9);
      wt(6);
      chk(rf_mute, 4'hF);
      m.set_rx(2'h1, 2'h0, 1'b1);
      wt(12);
      chk(rf_mute, 4'h0);
      apb(1'b1, rrs_pkg::ADDR_CONFIG, 32'h5);
      m.set_rx(2'h3, 2'h0, 1'b0);
      wt(12);
   endtask : t_solo
   task automatic t_mute;
      apb(1'b1, rrs_pkg::ADDR_MUTE, 32'h89);
      wt(2);
      chk(rf_mute, 4'hA);
      apb(1'b1, rrs_pkg::ADDR_MUTE, 32'hAA);
      wt(4);
      chk(alarm_led, 1'b1);
      apb(1'b1, rrs_pkg::ADDR_MUTE, 32'h55);
      wt(4);
      chk(rf_mute, 4'h0);
      apb(1'b1, rrs_pkg::ADDR_MUTE, 32'h0);
   endtask : t_mute
   task automatic t_atten;
      apb(1'b1, rrs_pkg::ADDR_ATT_HOST, 32'h19);
      apb(1'b1, rrs_pkg::ADDR_ATT_HOST + 8'h04, 32'hFFFFFFBA);
      apb(1'b1, rrs_pkg::ADDR_ATT_MGMT + 8'h08, 32'h3);
      apb(1'b1, rrs_pkg::ADDR_ATT_MGMT + 8'h0C, 32'hFFFFFFF4);
      wt(2);
      chk(rf_atten, 32'hC40FC419);
      apb(1'b0, rrs_pkg::ADDR_ATT_HOST + 8'h04, 32'h0);
      chk(q, 32'hFFFFFFC4);
   endtask : t_atten
   task automatic t_restore;
      apb(1'b1, rrs_pkg::ADDR_CONFIG, 32'h0);
      apb(1'b1, rrs_pkg::ADDR_RESTORE, 32'h1);
      wt(2);
      chk(band_sel, 2'h0);
      mgmt_access <= 1'b1;
      apb(1'b1, rrs_pkg::ADDR_RESTORE, 32'h1);
      wt(2);
      chk(band_sel, 2'h1);
      chk(rf_atten, 32'h0);
      mgmt_access <= 1'b0;
      apb(1'b0, 8'h08, 32'h0);
      chk(perr, 1'b1);
      chk(q, 32'h0);
   endtask : t_restore
   task automatic t_errors;
      pulse(5);
      apb(1'b0, rrs_pkg::ADDR_FER_CLR, 32'h0);
      chk(q, 32'h5);
      apb(1'b1, rrs_pkg::ADDR_CONFIG, 32'h45);
      pulse(3);
      apb(1'b0, rrs_pkg::ADDR_FER_CLR, 32'h0);
      chk(q, 32'h0);
      apb(1'b1, rrs_pkg::ADDR_CONFIG, 32'h5);
      pulse(2);
      apb(1'b0, rrs_pkg::ADDR_FER_CLR, 32'h0);
      chk(q, 32'h2);
   endtask : t_errors
   task automatic t_alarm;
      int n1 = 0;
      chk(alarm_led, 1'b0);
      alm <= 5'h04;
      wt(6);
      // Blink count allows any phase of the toggling lamp
      repeat (24) begin
         @(negedge ref_clk);
         n1 += alarm_led;
      end
      chk(n1 > 4 && n1 < 20, 1'b1);
      @(posedge ref_clk);
      alm <= 5'h0C;
      wt(4);
      repeat (12) begin
         @(negedge ref_clk);
         chk(alarm_led, 1'b1);
      end
      @(posedge ref_clk);
      alm <= 5'h01;
      wt(5);
      chk(alarm_led, 1'b1);
      alm <= 5'h00;
      wt(5);
      chk(alarm_led, 1'b0);
   endtask : t_alarm
   // ****************************************************************
   // Sequence and watchdog
   // ****************************************************************
   initial begin
      repeat (4) @(posedge ref_clk);
      rst_b <= 1'b1;
      t_band();
      t_select();
      t_solo();
      t_mute();
      t_atten();
      t_restore();
      t_errors();
      t_alarm();
      stop_test();
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      stop_test();
   end
endmodule : rrs_ctrl_tb
